// file: core/pafl_cfg.svh
// Offsets, field positions, reset values and timing counts of the fault and trap logic
`ifndef PAFL_CFG_SVH
`define PAFL_CFG_SVH
`define PAFL_CLK_PERIOD_NS    10
`define PAFL_DET_DLY_NS       50
`define PAFL_DET_DLY_CYC      ((`PAFL_DET_DLY_NS / `PAFL_CLK_PERIOD_NS) < 1 ? 1 : \
                               (`PAFL_DET_DLY_NS / `PAFL_CLK_PERIOD_NS))
`define PAFL_OFS_STATUS       2'h0
`define PAFL_OFS_VECTOR       2'h1
`define PAFL_BIT_NONRES       15
`define PAFL_BIT_LENGTH       14
`define PAFL_BIT_WPROT        13
`define PAFL_BIT_TRAP_DET     12
`define PAFL_BIT_TRAP_EN      9
`define PAFL_BIT_RELOCATION_ACTIVE        0
`define PAFL_STATUS_RESET     16'h0000
`define PAFL_TRAP_VECTOR      16'h00A8
`define PAFL_KEY_NONRES       3'h0
`define PAFL_KEY_RO_TRAP_WR   3'h1
`define PAFL_KEY_READ_ONLY    3'h2
`define PAFL_KEY_UNUSED_LO    3'h3
`define PAFL_KEY_TRAP_RW      3'h4
`define PAFL_KEY_TRAP_WR      3'h5
`define PAFL_KEY_UNUSED_HI    3'h7
`define PAFL_KEY_LSB          0
`define PAFL_MODE_ILLEGAL     2'h2
`define PAFL_DESC_ALL_ONES    16'hFFFF
`endif

// file: core/pafl_pkg.sv
// Types shared by the fault and trap logic
package pafl_pkg;
    typedef logic [2:0] pafl_key_t;
    typedef enum logic {
        PAFL_BUS_IDLE,
        PAFL_BUS_ANSWER
    } pafl_bus_state_t;
endpackage

// file: core/pafl_key_if.sv
// Carrier between access-key decoder and its users
`timescale 1ns/1ps
`default_nettype none
interface pafl_key_if;
    pafl_pkg::pafl_key_t key;
    logic                any_ref;
    logic                store_cycle;
    logic                nonres;
    logic                wprot;
    logic                trap_match;
    modport decode (input key, input any_ref, input store_cycle,
                    output nonres, output wprot, output trap_match);
    modport user (output key, output any_ref, output store_cycle,
                  input nonres, input wprot, input trap_match);
    modport watch (input key, input any_ref, input store_cycle,
                   input nonres, input wprot, input trap_match);
endinterface
`default_nettype wire

// file: core/pafl_key_decode.sv
// Access-key decoder: abort and trap detections for one reference
`include "pafl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pafl_key_decode (
    pafl_key_if.decode kif
);
    function automatic logic key_is(input pafl_pkg::pafl_key_t k, input pafl_pkg::pafl_key_t v);
        return k == v;
    endfunction

    // Unused keys behave as non-resident
    assign kif.nonres = kif.any_ref & (key_is(kif.key, `PAFL_KEY_NONRES)
                      | key_is(kif.key, `PAFL_KEY_UNUSED_LO)
                      | key_is(kif.key, `PAFL_KEY_UNUSED_HI));

    assign kif.wprot = kif.store_cycle & (key_is(kif.key, `PAFL_KEY_RO_TRAP_WR)
                     | key_is(kif.key, `PAFL_KEY_READ_ONLY));

    assign kif.trap_match = (kif.store_cycle & key_is(kif.key, `PAFL_KEY_RO_TRAP_WR))
                          | (kif.any_ref & key_is(kif.key, `PAFL_KEY_TRAP_RW))
                          | (kif.store_cycle & key_is(kif.key, `PAFL_KEY_TRAP_WR));
endmodule
`default_nettype wire

// file: core/pafl_stat_bits.sv
// Attention and written bit update pulses for the selected descriptor
`timescale 1ns/1ps
`default_nettype none
module pafl_stat_bits (
    input  wire logic  core_clk,
    input  wire logic  rst_n,
    pafl_key_if.watch  kif,
    input  wire logic  pause_t4_pulse,
    input  wire logic  relocation_active,
    input  wire logic  mm_reg_access,
    input  wire logic  combined_abort,
    output logic       desc_set_written,
    output logic       desc_set_attention
);
    logic page_active;
    assign page_active = relocation_active & ~mm_reg_access;

    // Recorded whatever the trap enable says
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            desc_set_written   <= 1'b0;
            desc_set_attention <= 1'b0;
        end else begin
            desc_set_written   <= pause_t4_pulse & page_active & kif.store_cycle
                                  & ~combined_abort;
            desc_set_attention <= pause_t4_pulse & page_active & kif.trap_match;
        end
    end
endmodule
`default_nettype wire

// file: core/pafl_trap_top.sv
// Page access fault, abort flag and statistics trap logic with its status register
`include "pafl_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module pafl_trap_top (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [1:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [15:0] page_descriptor,
    input  wire logic [15:0] processor_status_word,
    input  wire logic        read_cycle,
    input  wire logic        word_write_cycle,
    input  wire logic        byte_write_cycle,
    input  wire logic        read_pause_cycle,
    input  wire logic        bus_end_cycle,
    input  wire logic        mm_reg_access,
    input  wire logic        page_bound_fault,
    input  wire logic        pause_cycle,
    input  wire logic        pause_ts3_pulse,
    input  wire logic        pause_t4_pulse,
    input  wire logic        abort_acknowledge,
    input  wire logic        trap_acknowledge,
    output logic             mm_abort_flag,
    output logic             abort_pending,
    output logic             trap_request,
    output logic             desc_set_written,
    output logic             desc_set_attention,
    output logic [15:0]      fault_vector
);
    pafl_key_if kif ();

    pafl_pkg::pafl_bus_state_t bus_state;
    logic        fault_nonres;
    logic        fault_length;
    logic        fault_wprot;
    logic        trap_detected_bit;
    logic        trap_enable_bit;
    logic        relocation_active_enable;
    logic        trap_hold_latch;
    logic        detect_delay_block;
    logic [2:0]  dly_cnt;
    logic        relocation_active;
    logic        illegal_mode;
    logic [15:0] eff_descriptor;
    logic        combined_abort;
    logic        trap_qualify;
    logic        abort_take;
    logic        trap_take;
    logic        sw_wr_status;
    logic        wr_lo;
    logic        wr_hi;
    logic [15:0] status_word;
    logic [31:0] next_readdata;

    // Descriptor and cycle class into the decoder
    assign illegal_mode   = processor_status_word[15:14] == `PAFL_MODE_ILLEGAL;
    assign eff_descriptor = illegal_mode ? `PAFL_DESC_ALL_ONES : page_descriptor;
    assign kif.key        = eff_descriptor[`PAFL_KEY_LSB +: 3];
    assign kif.store_cycle = word_write_cycle | byte_write_cycle | read_pause_cycle;
    assign kif.any_ref    = read_cycle | kif.store_cycle;

    pafl_key_decode u_decode (
        .kif (kif.decode)
    );

    pafl_stat_bits u_stat (
        .core_clk           (core_clk),
        .rst_n              (rst_n),
        .kif                (kif.watch),
        .pause_t4_pulse     (pause_t4_pulse),
        .relocation_active  (relocation_active),
        .mm_reg_access      (mm_reg_access),
        .combined_abort     (combined_abort),
        .desc_set_written   (desc_set_written),
        .desc_set_attention (desc_set_attention)
    );

    assign relocation_active = relocation_active_enable;

    // Traps never feed the abort path, so the reference completes
    assign combined_abort = kif.nonres | kif.wprot | page_bound_fault;
    assign mm_abort_flag  = combined_abort & relocation_active & ~bus_end_cycle;
    assign trap_qualify   = kif.trap_match & relocation_active & ~mm_reg_access;

    assign abort_take = pause_ts3_pulse & mm_abort_flag;
    assign trap_take  = pause_ts3_pulse & trap_qualify & ~mm_abort_flag;

    // Request gate plus hold; processor samples it with its priority strobe at TS3
    assign trap_request = trap_hold_latch
                        | (pause_cycle & trap_enable_bit & ~abort_pending
                           & ~detect_delay_block & trap_qualify);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            abort_pending <= 1'b0;
        end else if (abort_take) begin
            abort_pending <= 1'b1;
        end else if (abort_acknowledge) begin
            abort_pending <= 1'b0;
        end
    end

    // Set wins over acknowledge so a trap arriving then is not lost
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            trap_hold_latch <= 1'b0;
        end else if (trap_take & trap_enable_bit & ~detect_delay_block) begin
            trap_hold_latch <= 1'b1;
        end else if (trap_acknowledge | abort_take | abort_pending) begin
            trap_hold_latch <= 1'b0;
        end
    end

    // Block rises a fixed delay after detection, clears only with bit 12
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dly_cnt            <= 3'h0;
            detect_delay_block <= 1'b0;
        end else if (!trap_detected_bit) begin
            dly_cnt            <= 3'h0;
            detect_delay_block <= 1'b0;
        end else if (!detect_delay_block) begin
            if (dly_cnt == 3'(`PAFL_DET_DLY_CYC - 1)) begin
                detect_delay_block <= 1'b1;
            end else begin
                dly_cnt <= dly_cnt + 3'h1;
            end
        end
    end

    // Avalon slave: one wait cycle, then answer
    assign avs_waitrequest = (avs_read | avs_write) & (bus_state != pafl_pkg::PAFL_BUS_ANSWER);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bus_state <= pafl_pkg::PAFL_BUS_IDLE;
        end else begin
            case (bus_state)
                pafl_pkg::PAFL_BUS_IDLE: begin
                    if (avs_read | avs_write) begin
                        bus_state <= pafl_pkg::PAFL_BUS_ANSWER;
                    end
                end
                pafl_pkg::PAFL_BUS_ANSWER: begin
                    bus_state <= pafl_pkg::PAFL_BUS_IDLE;
                end
                default: begin
                    bus_state <= pafl_pkg::PAFL_BUS_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        status_word = 16'h0000;
        status_word[`PAFL_BIT_NONRES]   = fault_nonres;
        status_word[`PAFL_BIT_LENGTH]   = fault_length;
        status_word[`PAFL_BIT_WPROT]    = fault_wprot;
        status_word[`PAFL_BIT_TRAP_DET] = trap_detected_bit;
        status_word[`PAFL_BIT_TRAP_EN]  = trap_enable_bit;
        status_word[`PAFL_BIT_RELOCATION_ACTIVE]    = relocation_active_enable;
    end

    always_comb begin
        if (avs_address == `PAFL_OFS_STATUS) begin
            next_readdata = {16'h0000, status_word};
        end else if (avs_address == `PAFL_OFS_VECTOR) begin
            next_readdata = {16'h0000, `PAFL_TRAP_VECTOR};
        end else begin
            next_readdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (bus_state == pafl_pkg::PAFL_BUS_IDLE && avs_read) begin
            avs_readdata <= next_readdata;
        end
    end

    assign sw_wr_status = (bus_state == pafl_pkg::PAFL_BUS_ANSWER) & avs_write
                        & (avs_address == `PAFL_OFS_STATUS);
    assign wr_lo = sw_wr_status & avs_byteenable[0];
    assign wr_hi = sw_wr_status & avs_byteenable[1];

    // Software writes; hardware sets win in the same cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fault_nonres <= 1'(`PAFL_STATUS_RESET >> `PAFL_BIT_NONRES);
            fault_length <= 1'b0;
            fault_wprot  <= 1'b0;
        end else begin
            if (abort_take & kif.nonres) begin
                fault_nonres <= 1'b1;
            end else if (wr_hi) begin
                fault_nonres <= avs_writedata[`PAFL_BIT_NONRES];
            end
            if (abort_take & page_bound_fault) begin
                fault_length <= 1'b1;
            end else if (wr_hi) begin
                fault_length <= avs_writedata[`PAFL_BIT_LENGTH];
            end
            if (abort_take & kif.wprot) begin
                fault_wprot <= 1'b1;
            end else if (wr_hi) begin
                fault_wprot <= avs_writedata[`PAFL_BIT_WPROT];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            trap_detected_bit <= 1'b0;
        end else if (trap_take) begin
            trap_detected_bit <= 1'b1;
        end else if (wr_hi) begin
            trap_detected_bit <= avs_writedata[`PAFL_BIT_TRAP_DET];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            trap_enable_bit <= 1'b0;
            relocation_active_enable    <= 1'b0;
        end else begin
            if (wr_hi) begin
                trap_enable_bit <= avs_writedata[`PAFL_BIT_TRAP_EN];
            end
            if (wr_lo) begin
                relocation_active_enable <= avs_writedata[`PAFL_BIT_RELOCATION_ACTIVE];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            fault_vector <= 16'h0000;
        end else begin
            fault_vector <= `PAFL_TRAP_VECTOR;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_illegal_mode_key: assert property (
        illegal_mode & kif.any_ref |-> kif.nonres & kif.key == `PAFL_KEY_UNUSED_HI)
        else $error("illegal mode did not force key 7 fault");
    a_readonly_write: assert property (
        kif.store_cycle & page_descriptor[2:0] == `PAFL_KEY_READ_ONLY & ~illegal_mode
        & relocation_active & ~bus_end_cycle |-> mm_abort_flag)
        else $error("write to read-only page not aborted");
    a_readonly_read: assert property (
        read_cycle & ~kif.store_cycle & kif.key == `PAFL_KEY_READ_ONLY
        & ~page_bound_fault |-> ~mm_abort_flag)
        else $error("read of read-only page aborted");
    a_abort_gate_bus_end_cycle: assert property (
        bus_end_cycle | ~relocation_active |-> ~mm_abort_flag)
        else $error("abort flag out of relocation or at bus end");
    a_abort_latch_ack: assert property (
        abort_take |=> abort_pending ##1 (abort_pending || $past(abort_acknowledge)))
        else $error("abort flip-flop not latched or lost");
    a_abort_clear_ack: assert property (
        abort_acknowledge & ~abort_take |=> ~abort_pending)
        else $error("abort flip-flop not cleared by acknowledge");
    a_trap_detect_set: assert property (
        trap_take |=> trap_detected_bit)
        else $error("trap detected bit not set at pause TS3");
    a_delay_block_rise: assert property (
        $rose(trap_detected_bit) |-> (~detect_delay_block)[*5]
        ##1 (detect_delay_block || ~trap_detected_bit))
        else $error("delay block not raised after detection");
    a_hold_keeps_req: assert property (
        trap_hold_latch |-> trap_request)
        else $error("hold latch set without trap request");
    a_trap_disabled: assert property (
        ~trap_enable_bit & ~trap_hold_latch |-> ~trap_request)
        else $error("trap raised while trap enable is clear");
    a_written_at_t4: assert property (
        pause_t4_pulse & relocation_active & ~mm_reg_access & kif.store_cycle
        & ~combined_abort |=> desc_set_written)
        else $error("written bit not set at pause T4");
    a_attention_t4: assert property (
        $rose(desc_set_attention) |-> $past(pause_t4_pulse) & $past(trap_qualify))
        else $error("attention bit set without trap condition at T4");
    a_nonres_bit_set: assert property (
        abort_take & kif.nonres |=> fault_nonres)
        else $error("non-resident bit not recorded");
    a_wprot_bit_set: assert property (
        abort_take & kif.wprot |=> fault_wprot)
        else $error("write-protect bit not recorded");
    a_req_pause_only: assert property (
        ~pause_cycle & ~trap_hold_latch |-> ~trap_request)
        else $error("trap request outside pause");
    a_hold_persists: assert property (
        trap_hold_latch & ~trap_acknowledge & ~abort_take & ~abort_pending |=> trap_hold_latch)
        else $error("hold latch lost early");
    a_hold_abort_clr: assert property (
        abort_take |=> ~trap_hold_latch)
        else $error("hold latch survived abort");
    a_block_stops_req: assert property (
        detect_delay_block & ~trap_hold_latch |-> ~trap_request)
        else $error("trap request while blocked");
    a_block_clear: assert property (
        ~trap_detected_bit |=> ~detect_delay_block)
        else $error("block kept after bit 12 clear");
    a_reset_clears: assert property (
        disable iff (1'b0) !rst_n |=> ~abort_pending & ~trap_hold_latch
        & ~trap_detected_bit & ~detect_delay_block)
        else $error("reset left abort or trap state");

    c_abort_taken:   cover property (abort_take ##[1:20] abort_acknowledge);
    c_trap_taken:    cover property (trap_take & trap_enable_bit ##1 trap_hold_latch);
    c_block_reached: cover property ($rose(detect_delay_block));
    c_written_pulse: cover property (desc_set_written);
    c_block_stops:   cover property (detect_delay_block & trap_take);
endmodule
`default_nettype wire

// file: bench/pafl_proc_model.sv
// Processor-side pause sequencer with abort and trap priority acknowledge
`timescale 1ns/1ps
`default_nettype none
module pafl_proc_model (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic       ack_en,
    input  wire logic       abort_pending,
    input  wire logic       trap_request,
    input  wire logic       desc_set_written,
    input  wire logic       desc_set_attention,
    output logic            pause_cycle,
    output logic            pause_ts3_pulse,
    output logic            pause_t4_pulse,
    output logic            abort_acknowledge,
    output logic            trap_acknowledge,
    output logic            done,
    output logic [3:0]      obs
);
    logic [2:0] step;
    logic       prio;
    logic       abt;
    logic [1:0] aw;
    assign pause_cycle     = (step >= 3'h1) && (step <= 3'h3);
    assign pause_ts3_pulse = (step == 3'h2);
    assign pause_t4_pulse  = (step == 3'h3);
    // Acks only after the pause: a trap is taken at instruction end
    assign abort_acknowledge = (step == 3'h5) && abt;
    assign trap_acknowledge  = (step == 3'h5) && prio && ack_en;
    assign done            = (step == 3'h6);
    assign obs             = {abt, prio, aw};
    always @(posedge core_clk) begin
        if (!rst_n) begin
            step <= 3'h0;
        end else if (step == 3'h0) begin
            step <= start ? 3'h1 : 3'h0;
        end else begin
            step <= (step == 3'h6) ? 3'h0 : step + 3'h1;
        end
    end
    always @(posedge core_clk) begin
        if (!rst_n || (step == 3'h0 && start)) begin
            prio <= 1'b0;
            abt  <= 1'b0;
            aw   <= 2'h0;
        end else if (step != 3'h0) begin
            if (pause_ts3_pulse) begin
                prio <= trap_request;
            end
            if (step == 3'h3) begin
                abt <= abort_pending;
            end
            aw <= aw | {desc_set_written, desc_set_attention};
        end
    end
endmodule
`default_nettype wire

// file: bench/page_access_fault_trap_logic_tb_top.sv
// Self-checking bench for the page fault, abort flag and trap logic
`timescale 1ns/1ps
`default_nettype none
module page_access_fault_trap_logic_tb_top;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [1:0]  avs_address = 2'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [15:0] page_descriptor = 16'h0000;
    logic [15:0] processor_status_word = 16'h0000;
    logic [3:0]  cyc = 4'h0;  // Read, word write, byte write, read-pause
    logic        bus_end_cycle = 1'b0;
    logic        mm_reg_access = 1'b0;
    logic        page_bound_fault = 1'b0;
    logic        pbf = 1'b0;
    logic        start = 1'b0;
    logic        ack_en = 1'b0;
    logic        pause_cycle, pause_ts3_pulse, pause_t4_pulse;
    logic        abort_acknowledge, trap_acknowledge, done;
    logic [3:0]  obs;
    logic        mm_abort_flag, abort_pending, trap_request;
    logic        desc_set_written, desc_set_attention;
    logic [15:0] fault_vector;
    logic [31:0] rq[$];
    logic [3:0]  pq[$];
    int          bad_count = 0;
    int          cmp_count = 0;
    integer      seed = 32'hc79d_46b5;

    always #5 core_clk = ~core_clk;

    pafl_trap_top pafl_trap_top_inst (
        .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .page_descriptor(page_descriptor),
        .processor_status_word(processor_status_word), .read_cycle(cyc[0]),
        .word_write_cycle(cyc[1]), .byte_write_cycle(cyc[2]), .read_pause_cycle(cyc[3]),
        .bus_end_cycle(bus_end_cycle), .mm_reg_access(mm_reg_access),
        .page_bound_fault(page_bound_fault), .pause_cycle(pause_cycle),
        .pause_ts3_pulse(pause_ts3_pulse), .pause_t4_pulse(pause_t4_pulse),
        .abort_acknowledge(abort_acknowledge), .trap_acknowledge(trap_acknowledge),
        .mm_abort_flag(mm_abort_flag), .abort_pending(abort_pending),
        .trap_request(trap_request), .desc_set_written(desc_set_written),
        .desc_set_attention(desc_set_attention), .fault_vector(fault_vector)
    );

    pafl_proc_model pafl_proc_model_inst (
        .core_clk(core_clk), .rst_n(rst_n), .start(start), .ack_en(ack_en),
        .abort_pending(abort_pending), .trap_request(trap_request),
        .desc_set_written(desc_set_written), .desc_set_attention(desc_set_attention),
        .pause_cycle(pause_cycle), .pause_ts3_pulse(pause_ts3_pulse),
        .pause_t4_pulse(pause_t4_pulse), .abort_acknowledge(abort_acknowledge),
        .trap_acknowledge(trap_acknowledge), .done(done), .obs(obs)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One Avalon access; read expectations go to the monitor's queue
    task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d,
                       input logic [3:0] be, input logic [31:0] e);
        int n;
        n = 0;
        if (!w) rq.push_back(e);
        @(posedge core_clk);
        avs_read <= ~w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        @(negedge core_clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 50) bad_count++;
        @(posedge core_clk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Reference under key k and cycle class c, then one pause cycle
    task automatic pause(input logic [2:0] k, input logic [3:0] c, input logic m,
                         input logic a, input logic [3:0] e);
        int n;
        n = 0;
        pq.push_back(e);
        @(posedge core_clk);
        page_descriptor <= {13'h0000, k};
        processor_status_word <= 16'h0000;
        cyc <= c;
        mm_reg_access <= m;
        bus_end_cycle <= 1'b0;
        page_bound_fault <= pbf;
        ack_en <= a;
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        @(negedge core_clk);
        while (done !== 1'b1 && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 50) bad_count++;
    endtask

    // Every key against every cycle class, legal and illegal mode
    task automatic sweep(input logic rel);
        logic [31:0] r;
        logic [2:0]  k;
        logic        st;
        logic        e;
        for (int j = 0; j < 64; j++) begin
            r = $random(seed);
            k = j[5] ? 3'h7 : j[2:0];
            st = (j[4:3] != 2'h0);
            e = (k == 3'h0) || (k == 3'h3) || (k == 3'h7) || (st && (k == 3'h1 || k == 3'h2));
            e = (e || r[31]) && rel && !r[30];
            @(posedge core_clk);
            page_descriptor <= {r[15:3], j[2:0]};
            processor_status_word <= {j[5], 1'b0, r[29:16]};
            cyc <= 4'h1 << j[4:3];
            bus_end_cycle <= r[30];
            page_bound_fault <= r[31];
            @(negedge core_clk);
            chk(mm_abort_flag, e);
            chk(trap_request, 1'b0);
        end
    endtask

    always @(negedge core_clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            chk(avs_readdata, rq.pop_front());
        end
        if (done === 1'b1) begin
            chk(obs, pq.pop_front());
        end
    end

    initial begin
        #200000;
        bad_count++;
        end_sim();
    end

    initial begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        bus(1'b0, 2'h0, 32'h0000_0000, 4'h0, 32'h0000_0000);
        bus(1'b0, 2'h1, 32'h0000_0000, 4'h0, 32'h0000_00a8);
        chk(fault_vector, 16'h00a8);
        bus(1'b1, 2'h1, 32'h0000_ffff, 4'hf, 32'h0000_0000);
        bus(1'b0, 2'h1, 32'h0000_0000, 4'h0, 32'h0000_00a8);
        bus(1'b0, 2'h2, 32'h0000_0000, 4'h0, 32'h0000_0000);
        sweep(1'b0);
        // Lane 0 alone reaches only the relocation bit
        bus(1'b1, 2'h0, 32'h0000_ffff, 4'h1, 32'h0000_0000);
        bus(1'b0, 2'h0, 32'h0000_0000, 4'h0, 32'h0000_0001);
        bus(1'b1, 2'h0, 32'h0000_0201, 4'h3, 32'h0000_0000);
        sweep(1'b1);
        pause(3'h0, 4'h1, 1'b0, 1'b1, 4'h8);
        chk(abort_pending, 1'b0);
        bus(1'b0, 2'h0, 32'h0000_0000, 4'h0, 32'h0000_8201);
        bus(1'b1, 2'h0, 32'h0000_0201, 4'h3, 32'h0000_0000);
        pause(3'h2, 4'h4, 1'b0, 1'b1, 4'h8);
        bus(1'b0, 2'h0, 32'h0000_0000, 4'h0, 32'h0000_2201);
        bus(1'b1, 2'h0, 32'h0000_0201, 4'h3, 32'h0000_0000);
        pause(3'h4, 4'h1, 1'b0, 1'b1, 4'h5);
        chk(trap_request, 1'b0);
        bus(1'b0, 2'h0, 32'h0000_0000, 4'h0, 32'h0000_1201);
        pause(3'h4, 4'h1, 1'b0, 1'b1, 4'h1);
        bus(1'b1, 2'h0, 32'h0000_0201, 4'h3, 32'h0000_0000);
        pause(3'h5, 4'h2, 1'b0, 1'b0, 4'h7);
        chk(trap_request, 1'b1);
        // Reset in mid-run with a trap held, before the block has risen
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk(trap_request, 1'b0);
        chk(abort_pending, 1'b0);
        chk(fault_vector, 16'h0000);
        @(posedge core_clk);
        rst_n <= 1'b1;
        bus(1'b0, 2'h0, 32'h0000_0000, 4'h0, 32'h0000_0000);
        bus(1'b1, 2'h0, 32'h0000_0001, 4'h3, 32'h0000_0000);
        pause(3'h5, 4'h8, 1'b0, 1'b1, 4'h3);
        bus(1'b0, 2'h0, 32'h0000_0000, 4'h0, 32'h0000_1001);
        bus(1'b1, 2'h0, 32'h0000_0001, 4'h3, 32'h0000_0000);
        pause(3'h4, 4'h1, 1'b1, 1'b1, 4'h0);
        bus(1'b0, 2'h0, 32'h0000_0000, 4'h0, 32'h0000_0001);
        pbf = 1'b1;
        pause(3'h6, 4'h1, 1'b0, 1'b1, 4'h8);
        bus(1'b0, 2'h0, 32'h0000_0000, 4'h0, 32'h0000_4001);
        repeat (4) @(posedge core_clk);
        end_sim();
    end
endmodule
`default_nettype wire
